// >>> rtl/mpc_defines.svh
// Offsets, field positions, reset values and timing figures of the configuration block
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define MPC_OFS_PCFG 12'h0A8
`define MPC_OFS_GDCFG 12'h0AC
`define MPC_OFS_STAT 12'h0B0
`define MPC_OFS_PASS 12'h0B4

// ==========================================================
// Reset values and writable-bit masks
`define MPC_PCFG_RST 32'h0000_0000
`define MPC_GDCFG_RST 32'h0000_0000
`define MPC_PASS_RST 32'h0000_0000
`define MPC_PCFG_WMASK 32'hDFFF_FFE0
`define MPC_GDCFG_WMASK 32'h8C0D_3703
`define MPC_PASSCODE 32'h0000_1234

// ==========================================================
// Field positions in the peripheral configuration register
`define MPC_DIRMODE_BIT 18
`define MPC_SPDCAP_BIT 17
`define MPC_GAP_HI 16
`define MPC_GAP_LO 13
`define MPC_MOD_HI 12
`define MPC_MOD_LO 10
`define MPC_BAND_BIT 9
`define MPC_REF_HI 8
`define MPC_REF_LO 7
`define MPC_LOCK_HI 6
`define MPC_LOCK_LO 5

// ==========================================================
// Braking threshold code tables
`define MPC_GAP_STEP_LO 5
`define MPC_GAP_KNEE 10
`define MPC_GAP_KNEE_PCT 50
`define MPC_GAP_STEP_HI 10
`define MPC_MOD_BASE_PCT 30
`define MPC_MOD_STEP 10

// ==========================================================
// Duty input frequency bands and clock
`define MPC_CLK_HZ 50000000
`define MPC_DUTY_FMAX_HZ 100000
`define MPC_DUTY_FMID_HZ 325
`define MPC_DUTY_FMIN_HZ 10

// Full scale of the modulation index reference (100%)
`define MPC_MOD_FULL 16'hFFFF

`endif

// >>> rtl/mpc_pkg.sv
// Types shared by the configuration block modules
package mpc_pkg;

  // ==========================================================
  // Direction handling states
  typedef enum logic [3:0] {
    MPC_RUN  = 4'b0001,
    MPC_STOP = 4'b0010,
    MPC_ISD  = 4'b0100,
    MPC_REV  = 4'b1000
  } mpc_dir_state_t;

  typedef enum logic [1:0] {
    MPC_REF_SPEED  = 2'h0,
    MPC_REF_POWER  = 2'h1,
    MPC_REF_TORQUE = 2'h2,
    MPC_REF_MOD    = 2'h3
  } mpc_ref_mode_t;

  typedef enum logic [1:0] {
    MPC_LOCK_OPEN    = 2'h0,
    MPC_LOCK_PASS_RW = 2'h1,
    MPC_LOCK_PASS_RD = 2'h2,
    MPC_LOCK_SEALED  = 2'h3
  } mpc_lock_mode_t;

  // ==========================================================
  // Module state records
  typedef struct packed {
    logic [31:0] pcfg;
    logic [31:0] gdcfg;
    logic [31:0] pass;
    logic [31:0] prdata;
    mpc_dir_state_t st;
    logic dir_active;
    logic [15:0] speed_target;
    logic [15:0] loop_set;
    logic duty_ok;
  } mpc_core_state_t;

  typedef struct packed {
    logic brake;
  } mpc_brake_state_t;

endpackage

// >>> rtl/mpc_brake_thresh.sv
// Active braking entry decision from the two threshold codes
`include "mpc_defines.svh"

module mpc_brake_thresh (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] gap_code,
  input wire logic [2:0] mod_code,
  input wire logic [6:0] speed_gap_pct,
  input wire logic [6:0] mod_index_pct,
  output logic brake_engage
);
  import mpc_pkg::*;

  // ==========================================================
  // Code tables
  function automatic logic [6:0] mpc_gap_limit(input logic [3:0] code);
    int c;
    c = int'(code);
    if (c <= `MPC_GAP_KNEE) begin
      return 7'(c * `MPC_GAP_STEP_LO);
    end
    return 7'(`MPC_GAP_KNEE_PCT + (c - `MPC_GAP_KNEE) * `MPC_GAP_STEP_HI);
  endfunction

  function automatic logic [6:0] mpc_mod_limit(input logic [2:0] code);
    int c;
    c = int'(code);
    if (c == 0) begin
      return 7'h00;
    end
    return 7'(`MPC_MOD_BASE_PCT + c * `MPC_MOD_STEP);
  endfunction

  // ==========================================================
  // Decision register
  mpc_brake_state_t s_r;
  mpc_brake_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // Code 0 of the gap field disables braking entry altogether
    s_nxt.brake = (gap_code != 4'h0) &&
                  (speed_gap_pct < mpc_gap_limit(gap_code)) &&
                  (mod_index_pct < mpc_mod_limit(mod_code));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign brake_engage = s_r.brake;

endmodule

// >>> rtl/mpc_nvm_guard.sv
// Nonvolatile memory access gate driven by the lock level
module mpc_nvm_guard (
  input wire mpc_pkg::mpc_lock_mode_t lock_mode,
  input wire logic passcode_ok,
  input wire logic rd_req,
  input wire logic wr_req,
  output logic rd_grant,
  output logic wr_grant,
  output logic rd_refuse,
  output logic wr_refuse
);
  import mpc_pkg::*;

  logic rd_ok;
  logic wr_ok;

  always_comb begin
    unique case (lock_mode)
      MPC_LOCK_OPEN: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      MPC_LOCK_PASS_RW: begin
        rd_ok = passcode_ok;
        wr_ok = passcode_ok;
      end
      MPC_LOCK_PASS_RD: begin
        rd_ok = passcode_ok;
        wr_ok = 1'b0;
      end
      MPC_LOCK_SEALED: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  assign rd_grant = rd_req && rd_ok;
  assign wr_grant = wr_req && wr_ok;
  assign rd_refuse = rd_req && !rd_ok;
  assign wr_refuse = wr_req && !wr_ok;

endmodule

// >>> rtl/mpc_periph_cfg.sv
// Peripheral and gate driver configuration registers with their control effects
//
// Function
// - Direction response mode is read/write bit 18, reset zero.
// - Mode 0 stops then spin-detects on direction change; mode 1 reverses while driving.
// - Speed cap bit 17 limits speed to top speed except in speed mode.
// - Bits 16-13 set braking speed gap: 0 none, 5%-50%, then 60%-100%.
// - Bits 12-10 set braking modulation threshold: 0%, then 40%-100% by 10%.
// - Bit 9 picks duty input band: 0 is 325Hz-100kHz, 1 is 10Hz-325Hz.
// - Bits 8-7 pick loop quantity: speed, power, torque current, modulation index.
// - Lock code 0 opens memory; code 1 needs passcode for reads and writes.
// - Lock code 2 passcode reads, no writes; code 3 refuses both.
// - Gate driver register lives at offset ACh, resets to all zeros.
// - Gate driver register is kept apart from the peripheral register.
`include "mpc_defines.svh"

module mpc_periph_cfg #(
  parameter int unsigned DUTY_W = 23,
  parameter int unsigned DUTY_PER_MIN = `MPC_CLK_HZ / `MPC_DUTY_FMAX_HZ,
  parameter int unsigned DUTY_PER_MID = `MPC_CLK_HZ / `MPC_DUTY_FMID_HZ,
  parameter int unsigned DUTY_PER_MAX = `MPC_CLK_HZ / `MPC_DUTY_FMIN_HZ,
  parameter logic [31:0] PASSCODE = `MPC_PASSCODE
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Direction pin handling
  input wire logic dir_pin,
  input wire logic stop_done,
  input wire logic isd_done,
  input wire logic reverse_done,
  output logic dir_active,
  output logic drive_enable,
  output logic stop_req,
  output logic initial_spin_detect_req,
  output logic reverse_req,
  // Speed and loop reference
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] max_speed,
  input wire logic [15:0] max_power,
  input wire logic [15:0] current_ceiling,
  input wire logic [15:0] ref_in,
  output logic [15:0] speed_target,
  output logic [15:0] loop_setpoint,
  output mpc_pkg::mpc_ref_mode_t loop_mode,
  // Active braking
  input wire logic [6:0] speed_gap_pct,
  input wire logic [6:0] mod_index_pct,
  output logic brake_engage,
  // Duty reference period check
  input wire logic [DUTY_W-1:0] duty_period,
  input wire logic duty_period_valid,
  output logic duty_freq_ok,
  output logic duty_band_low,
  // Nonvolatile memory access
  input wire logic nvm_rd_req,
  input wire logic nvm_wr_req,
  output logic nvm_rd_grant,
  output logic nvm_wr_grant,
  output logic nvm_rd_refuse,
  output logic nvm_wr_refuse,
  // Gate driver settings
  output logic [31:0] gate_driver_config_one
);
  import mpc_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (DUTY_PER_MIN == 0 || DUTY_PER_MIN >= DUTY_PER_MID || DUTY_PER_MID >= DUTY_PER_MAX) begin
    $error("Duty period bounds must rise strictly from a nonzero minimum");
  end
  if (DUTY_W > 31 || DUTY_PER_MAX >= (32'h1 << DUTY_W)) begin
    $error("Duty period width too small for the longest period");
  end
  // A passcode equal to the cleared register would unlock memory straight after reset
  if (PASSCODE == `MPC_PASS_RST) begin
    $error("Passcode must differ from the reset value of its register");
  end

  localparam logic [DUTY_W-1:0] PER_MIN = DUTY_W'(DUTY_PER_MIN);
  localparam logic [DUTY_W-1:0] PER_MID = DUTY_W'(DUTY_PER_MID);
  localparam logic [DUTY_W-1:0] PER_MAX = DUTY_W'(DUTY_PER_MAX);

  // ==========================================================
  // Address decode
  function automatic logic mpc_hit(input logic [11:0] a);
    return (a == `MPC_OFS_PCFG) || (a == `MPC_OFS_GDCFG) ||
           (a == `MPC_OFS_STAT) || (a == `MPC_OFS_PASS);
  endfunction

  // ==========================================================
  // Duty period window, inclusive at both ends
  // PER_MID sits in both bands, so a period right at the corner passes either way
  function automatic logic mpc_in_band(input logic [DUTY_W-1:0] p, lo, hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // ==========================================================
  // State
  mpc_core_state_t s_r;
  mpc_core_state_t s_nxt;

  logic setup_ph;
  logic wr_acc;
  logic passcode_ok;
  logic dir_mode;
  logic spd_cap;
  logic band_low;
  mpc_ref_mode_t ref_mode;
  mpc_lock_mode_t lock_mode;
  logic [15:0] ref_scale;
  logic [31:0] ref_prod;
  logic [31:0] stat_word;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign passcode_ok = (s_r.pass == PASSCODE);

  assign dir_mode = s_r.pcfg[`MPC_DIRMODE_BIT];
  assign spd_cap = s_r.pcfg[`MPC_SPDCAP_BIT];
  assign band_low = s_r.pcfg[`MPC_BAND_BIT];
  assign ref_mode = mpc_ref_mode_t'(s_r.pcfg[`MPC_REF_HI:`MPC_REF_LO]);
  assign lock_mode = mpc_lock_mode_t'(s_r.pcfg[`MPC_LOCK_HI:`MPC_LOCK_LO]);

  // ==========================================================
  // Status word: state, direction, brake, duty window, passcode match
  assign stat_word = {24'h00_0000, passcode_ok, s_r.duty_ok, brake_engage,
                      s_r.dir_active, s_r.st};

  // ==========================================================
  // Loop reference scaling
  always_comb begin
    unique case (ref_mode)
      MPC_REF_SPEED: ref_scale = max_speed;
      MPC_REF_POWER: ref_scale = max_power;
      MPC_REF_TORQUE: ref_scale = current_ceiling;
      MPC_REF_MOD: ref_scale = `MPC_MOD_FULL;
    endcase
  end

  // Upper half of the product gives the chosen limit at full-scale input
  assign ref_prod = ref_in * ref_scale;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;

    // Read data captured in the setup phase so it comes from a flop
    if (setup_ph) begin
      unique case (paddr)
        `MPC_OFS_PCFG: s_nxt.prdata = s_r.pcfg;
        `MPC_OFS_GDCFG: s_nxt.prdata = s_r.gdcfg;
        `MPC_OFS_STAT: s_nxt.prdata = stat_word;
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // Writes land at the access edge; reserved bits stay zero
    if (wr_acc) begin
      unique case (paddr)
        `MPC_OFS_PCFG: begin
          s_nxt.pcfg = pwdata & `MPC_PCFG_WMASK;
        end
        `MPC_OFS_GDCFG: begin
          s_nxt.gdcfg = pwdata & `MPC_GDCFG_WMASK;
        end
        // Write-only, so the code can never be read back over the bus
        `MPC_OFS_PASS: begin
          s_nxt.pass = pwdata;
        end
        default: begin
        end
      endcase
    end

    // Direction change handling
    // Pin moves during a sequence are compared again once RUN returns
    unique case (s_r.st)
      MPC_RUN: begin
        if (dir_pin != s_r.dir_active) begin
          if (dir_mode) begin
            s_nxt.st = MPC_REV;
            s_nxt.dir_active = dir_pin;
          end else begin
            s_nxt.st = MPC_STOP;
          end
        end
      end
      MPC_STOP: begin
        if (stop_done) begin
          // Latest pin level is taken here so late toggles are not lost
          s_nxt.st = MPC_ISD;
          s_nxt.dir_active = dir_pin;
        end
      end
      MPC_ISD: begin
        if (isd_done) begin
          s_nxt.st = MPC_RUN;
        end
      end
      MPC_REV: begin
        if (reverse_done) begin
          s_nxt.st = MPC_RUN;
        end
      end
      default: begin
        s_nxt.st = MPC_RUN;
      end
    endcase

    // Speed cap, off in speed mode where the reference is the speed itself
    // Cap only ever lowers the command; slower commands pass untouched
    if (spd_cap && ref_mode != MPC_REF_SPEED && speed_cmd > max_speed) begin
      s_nxt.speed_target = max_speed;
    end else begin
      s_nxt.speed_target = speed_cmd;
    end

    s_nxt.loop_set = ref_prod[31:16];

    // Duty input period must sit inside the selected band
    if (duty_period_valid) begin
      if (band_low) begin
        s_nxt.duty_ok = mpc_in_band(duty_period, PER_MID, PER_MAX);
      end else begin
        s_nxt.duty_ok = mpc_in_band(duty_period, PER_MIN, PER_MID);
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.pcfg <= `MPC_PCFG_RST;
      s_r.gdcfg <= `MPC_GDCFG_RST;
      s_r.pass <= `MPC_PASS_RST;
      s_r.prdata <= 32'h0000_0000;
      s_r.st <= MPC_RUN;
      s_r.dir_active <= 1'b0;
      s_r.speed_target <= 16'h0000;
      s_r.loop_set <= 16'h0000;
      s_r.duty_ok <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Submodules
  mpc_brake_thresh u_brake (
    .pclk(pclk),
    .presetn(presetn),
    .gap_code(s_r.pcfg[`MPC_GAP_HI:`MPC_GAP_LO]),
    .mod_code(s_r.pcfg[`MPC_MOD_HI:`MPC_MOD_LO]),
    .speed_gap_pct(speed_gap_pct),
    .mod_index_pct(mod_index_pct),
    .brake_engage(brake_engage)
  );

  // Memory gate is combinational so a request is answered in its own cycle
  mpc_nvm_guard u_nvm (
    .lock_mode(lock_mode),
    .passcode_ok(passcode_ok),
    .rd_req(nvm_rd_req),
    .wr_req(nvm_wr_req),
    .rd_grant(nvm_rd_grant),
    .wr_grant(nvm_wr_grant),
    .rd_refuse(nvm_rd_refuse),
    .wr_refuse(nvm_wr_refuse)
  );

  // ==========================================================
  // Outputs
  // Zero-wait slave: read data was already captured in setup
  assign pready = 1'b1;
  // Unmapped access flags an error; a write there changes nothing
  assign pslverr = psel && penable && !mpc_hit(paddr);
  assign prdata = s_r.prdata;

  assign dir_active = s_r.dir_active;
  // Bridge stays driven through reverse; stop and spin detection release it
  assign drive_enable = s_r.st[0] || s_r.st[3];
  assign stop_req = s_r.st[1];
  assign initial_spin_detect_req = s_r.st[2];
  assign reverse_req = s_r.st[3];

  assign speed_target = s_r.speed_target;
  assign loop_setpoint = s_r.loop_set;
  assign loop_mode = ref_mode;
  assign duty_freq_ok = s_r.duty_ok;
  assign duty_band_low = band_low;
  assign gate_driver_config_one = s_r.gdcfg;

endmodule

// >>> sim/mpc_periph_cfg_chk.sv
// Port-level assertion checker for the configuration block
`include "mpc_defines.svh"
module mpc_periph_cfg_chk #(
  parameter int unsigned DUTY_W = 23,
  parameter int unsigned DUTY_PER_MIN = `MPC_CLK_HZ / `MPC_DUTY_FMAX_HZ,
  parameter int unsigned DUTY_PER_MID = `MPC_CLK_HZ / `MPC_DUTY_FMID_HZ,
  parameter int unsigned DUTY_PER_MAX = `MPC_CLK_HZ / `MPC_DUTY_FMIN_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic dir_pin,
  input wire logic dir_active,
  input wire logic drive_enable,
  input wire logic stop_req,
  input wire logic initial_spin_detect_req,
  input wire logic reverse_req,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] max_speed,
  input wire logic [15:0] max_power,
  input wire logic [15:0] current_ceiling,
  input wire logic [15:0] ref_in,
  input wire logic [15:0] speed_target,
  input wire logic [15:0] loop_setpoint,
  input wire mpc_pkg::mpc_ref_mode_t loop_mode,
  input wire logic [6:0] speed_gap_pct,
  input wire logic [6:0] mod_index_pct,
  input wire logic brake_engage,
  input wire logic [DUTY_W-1:0] duty_period,
  input wire logic duty_period_valid,
  input wire logic duty_freq_ok,
  input wire logic duty_band_low,
  input wire logic nvm_rd_req,
  input wire logic nvm_wr_req,
  input wire logic nvm_rd_grant,
  input wire logic nvm_wr_grant,
  input wire logic nvm_rd_refuse,
  input wire logic nvm_wr_refuse,
  input wire logic [31:0] gate_driver_config_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Register shadows; delayed copies tolerate one cycle of field pipelining
  logic [31:0] cfg_r, cfg_q, gd_r, gd_q, pass_r, pass_q;
  logic [15:0] spd_x, scl, sp_x;
  logic [6:0] glim, mlim;
  logic brk_x, rd_x, wr_x, duty_x, calm;
  wire wr = psel && penable && pwrite;
  wire run = !stop_req && !initial_spin_detect_req && !reverse_req;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cfg_r, cfg_q, gd_r, gd_q, pass_r, pass_q} <= '0;
    end else begin
      {cfg_q, gd_q, pass_q} <= {cfg_r, gd_r, pass_r};
      if (wr && paddr == `MPC_OFS_PCFG) cfg_r <= pwdata & `MPC_PCFG_WMASK;
      if (wr && paddr == `MPC_OFS_GDCFG) gd_r <= pwdata & `MPC_GDCFG_WMASK;
      if (wr && paddr == `MPC_OFS_PASS) pass_r <= pwdata;
    end
  end
  always_comb begin
    calm = cfg_q == cfg_r && pass_q == pass_r;
    glim = cfg_r[16:13] <= 4'hA ? 7'(5 * cfg_r[16:13]) : 7'(10 * cfg_r[16:13] - 50);
    mlim = cfg_r[12:10] == 3'h0 ? 7'h00 : 7'(30 + 10 * cfg_r[12:10]);
    brk_x = cfg_r[16:13] != 4'h0 && speed_gap_pct < glim && mod_index_pct < mlim;
    spd_x = cfg_r[17] && cfg_r[8:7] != 2'h0 && speed_cmd > max_speed ? max_speed : speed_cmd;
    scl = cfg_r[8] ? (cfg_r[7] ? `MPC_MOD_FULL : current_ceiling)
                   : (cfg_r[7] ? max_power : max_speed);
    sp_x = 16'((32'(ref_in) * 32'(scl)) >> 16);
    rd_x = cfg_r[6:5] == 2'h0 || (cfg_r[6:5] != 2'h3 && pass_r == `MPC_PASSCODE);
    wr_x = cfg_r[6:5] == 2'h0 || (cfg_r[6:5] == 2'h1 && pass_r == `MPC_PASSCODE);
    duty_x = cfg_r[9] ? duty_period >= DUTY_PER_MID && duty_period <= DUTY_PER_MAX
                      : duty_period >= DUTY_PER_MIN && duty_period <= DUTY_PER_MID;
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====
  // Assertions
  a_dir_stop:
    assert property (run && dir_pin != dir_active && !cfg_r[18] |=> stop_req && !drive_enable)
      else $error("direction stop not raised");
  a_dir_reverse:
    assert property (run && dir_pin != dir_active && cfg_r[18]
      |=> reverse_req && drive_enable && dir_active == $past(dir_pin))
      else $error("reverse drive not raised");
  a_speed_cap:
    assert property (calm |=> speed_target == $past(spd_x)) else $error("speed cap wrong");
  a_brake_entry:
    assert property (calm |=> brake_engage == $past(brk_x)) else $error("brake decision wrong");
  a_duty_band:
    assert property (calm && duty_period_valid |=> duty_freq_ok == $past(duty_x))
      else $error("duty band check wrong");
  a_field_copy:
    assert property (calm |-> loop_mode == cfg_r[8:7] && duty_band_low == cfg_r[9])
      else $error("field copy wrong");
  a_loop_scale:
    assert property (calm |=> loop_setpoint == $past(sp_x)) else $error("setpoint wrong");
  a_nvm_gate:
    assert property (calm |-> {nvm_rd_grant, nvm_rd_refuse, nvm_wr_grant, nvm_wr_refuse}
      == {nvm_rd_req && rd_x, nvm_rd_req && !rd_x, nvm_wr_req && wr_x, nvm_wr_req && !wr_x})
      else $error("memory gate wrong");
  a_gate_copy:
    assert property (gd_q == gd_r |-> gate_driver_config_one == gd_r)
      else $error("gate driver copy wrong");
endmodule

bind mpc_periph_cfg mpc_periph_cfg_chk #(
  .DUTY_W(DUTY_W), .DUTY_PER_MIN(DUTY_PER_MIN), .DUTY_PER_MID(DUTY_PER_MID),
  .DUTY_PER_MAX(DUTY_PER_MAX)
) u_chk (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .dir_pin, .dir_active,
  .drive_enable, .stop_req, .initial_spin_detect_req, .reverse_req, .speed_cmd, .max_speed,
  .max_power, .current_ceiling, .ref_in, .speed_target, .loop_setpoint, .loop_mode,
  .speed_gap_pct, .mod_index_pct, .brake_engage, .duty_period, .duty_period_valid,
  .duty_freq_ok, .duty_band_low, .nvm_rd_req, .nvm_wr_req, .nvm_rd_grant, .nvm_wr_grant,
  .nvm_rd_refuse, .nvm_wr_refuse, .gate_driver_config_one
);

// >>> sim/testbench.sv
// Self-checking bench for the peripheral configuration block
`include "mpc_defines.svh"
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mpc_pkg::*;
  // ====
  // Short duty bounds keep the run brief
  localparam int unsigned PMIN = 5;
  localparam int unsigned PMID = 20;
  localparam int unsigned PMAX = 80;
  localparam int PER [5] = '{4, 5, 20, 80, 81};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ex;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, gate_driver_config_one, rd, cfg_m, gd_m, pass_m;
  logic dir_pin, stop_done, isd_done, reverse_done, dir_active, drive_enable, stop_req;
  logic initial_spin_detect_req, reverse_req, brake_engage, duty_period_valid, duty_freq_ok;
  logic duty_band_low, nvm_rd_req, nvm_wr_req, nvm_rd_grant, nvm_wr_grant, nvm_rd_refuse;
  logic nvm_wr_refuse;
  logic [15:0] speed_cmd, max_speed, max_power, current_ceiling, ref_in, speed_target;
  logic [15:0] loop_setpoint, scale;
  logic [6:0] speed_gap_pct, mod_index_pct;
  logic [22:0] duty_period;
  mpc_ref_mode_t loop_mode;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 19;
  int g, m, k;
  mpc_periph_cfg #(.DUTY_PER_MIN(PMIN), .DUTY_PER_MID(PMID), .DUTY_PER_MAX(PMAX)) dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .dir_pin, .stop_done, .isd_done, .reverse_done, .dir_active, .drive_enable, .stop_req,
    .initial_spin_detect_req, .reverse_req, .speed_cmd, .max_speed, .max_power,
    .current_ceiling, .ref_in, .speed_target, .loop_setpoint, .loop_mode, .speed_gap_pct,
    .mod_index_pct, .brake_engage, .duty_period, .duty_period_valid, .duty_freq_ok,
    .duty_band_low, .nvm_rd_req, .nvm_wr_req, .nvm_rd_grant, .nvm_wr_grant, .nvm_rd_refuse,
    .nvm_wr_refuse, .gate_driver_config_one);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ====
  // Bus cycles and model
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (w && a == `MPC_OFS_PCFG) cfg_m = d & `MPC_PCFG_WMASK;
    if (w && a == `MPC_OFS_GDCFG) gd_m = d & `MPC_GDCFG_WMASK;
    if (w && a == `MPC_OFS_PASS) pass_m = d;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask
  // Results registered at the edge are read half a cycle later, free of races
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pulse(input int w);
    @(posedge pclk);
    {stop_done, isd_done, reverse_done} <= 3'(w);
    @(posedge pclk);
    {stop_done, isd_done, reverse_done} <= 3'h0;
    @(negedge pclk);
  endtask
  function automatic int gl(int c);
    return c <= 10 ? 5 * c : 10 * c - 50;
  endfunction
  function automatic int ml(int c);
    return c == 0 ? 0 : 30 + 10 * c;
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cfg_m, gd_m, pass_m} = '0;
    {dir_pin, stop_done, isd_done, reverse_done, duty_period_valid} = '0;
    {nvm_rd_req, nvm_wr_req, speed_cmd, max_speed, max_power, current_ceiling, ref_in} = '0;
    {speed_gap_pct, mod_index_pct, duty_period} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`MPC_OFS_PCFG, 32'h0);
    rchk(`MPC_OFS_GDCFG, 32'h0);
    repeat (6) begin
      apb(1'b1, `MPC_OFS_PCFG, $random(seed));
      apb(1'b1, `MPC_OFS_GDCFG, $random(seed));
      rchk(`MPC_OFS_PCFG, cfg_m);
      rchk(`MPC_OFS_GDCFG, gd_m);
      `CHK("gdcfg_out", gd_m, gate_driver_config_one)
    end
    apb(1'b1, 12'h0C0, 32'hFFFF_FFFF);
    `CHK("pslverr", 1'b1, err)
    rchk(`MPC_OFS_PCFG, cfg_m);
    for (g = 0; g < 16; g++) begin
      for (m = 0; m < 8; m++) begin
        apb(1'b1, `MPC_OFS_PCFG, 32'(g) << 13 | 32'(m) << 10);
        k = gl(g) + {$random(seed)} % 3 - 1;
        speed_gap_pct <= 7'(k);
        mod_index_pct <= 7'(ml(m) + {$random(seed)} % 3 - 1);
        settle(1);
        ex = g != 0 && int'(speed_gap_pct) < gl(g) && int'(mod_index_pct) < ml(m);
        `CHK("brake", ex, brake_engage)
      end
    end
    for (m = 0; m < 8; m++) begin
      apb(1'b1, `MPC_OFS_PCFG, 32'(m % 4) << 7 | 32'(m / 4) << 17);
      {speed_cmd, max_speed, max_power, current_ceiling, ref_in} <=
        {$random(seed), $random(seed), 16'($random(seed))};
      settle(2);
      scale = m % 4 == 0 ? max_speed : m % 4 == 1 ? max_power : m % 4 == 2 ? current_ceiling
        : 16'hFFFF;
      `CHK("setpoint", 16'((32'(ref_in) * 32'(scale)) >> 16), loop_setpoint)
      `CHK("mode", 2'(m), loop_mode)
      `CHK("speed", m > 4 && speed_cmd > max_speed ? max_speed : speed_cmd, speed_target)
    end
    for (m = 0; m < 8; m++) begin
      apb(1'b1, `MPC_OFS_PASS, m % 2 ? `MPC_PASSCODE : $random(seed));
      apb(1'b1, `MPC_OFS_PCFG, 32'(m / 2) << 5);
      {nvm_rd_req, nvm_wr_req} <= 2'b11;
      settle(1);
      ex = m < 2 || (m < 6 && pass_m == `MPC_PASSCODE);
      `CHK("nvm_rd", {ex, !ex}, {nvm_rd_grant, nvm_rd_refuse})
      ex = m < 2 || (m / 2 == 1 && pass_m == `MPC_PASSCODE);
      `CHK("nvm_wr", {ex, !ex}, {nvm_wr_grant, nvm_wr_refuse})
    end
    rchk(`MPC_OFS_PASS, 32'h0);
    for (m = 0; m < 10; m++) begin
      apb(1'b1, `MPC_OFS_PCFG, 32'(m / 5) << 9);
      {nvm_rd_req, nvm_wr_req, duty_period_valid} <= 3'b001;
      duty_period <= 23'(PER[m % 5]);
      @(posedge pclk);
      duty_period_valid <= 1'b0;
      settle(0);
      k = PER[m % 5];
      ex = m < 5 ? k >= PMIN && k <= PMID : k >= PMID && k <= PMAX;
      `CHK("duty_ok", ex, duty_freq_ok)
      `CHK("band", 1'(m / 5), duty_band_low)
    end
    apb(1'b1, `MPC_OFS_PCFG, 32'h0);
    dir_pin <= 1'b1;
    settle(3);
    `CHK("stop", 2'b10, {stop_req, drive_enable})
    rchk(`MPC_OFS_STAT, {24'h00_0000, pass_m == `MPC_PASSCODE, 7'h02});
    pulse(4);
    `CHK("isd", 3'b110, {initial_spin_detect_req, dir_active, drive_enable})
    pulse(2);
    `CHK("run", 3'b001, {initial_spin_detect_req, stop_req, drive_enable})
    apb(1'b1, `MPC_OFS_PCFG, 32'h1 << 18);
    dir_pin <= 1'b0;
    settle(2);
    `CHK("rev", 3'b101, {reverse_req, dir_active, drive_enable})
    pulse(1);
    `CHK("rev_end", 2'b01, {reverse_req, drive_enable})
    // Second reset mid-run must clear both registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {cfg_m, gd_m} = '0;
    rchk(`MPC_OFS_PCFG, 32'h0);
    rchk(`MPC_OFS_GDCFG, 32'h0);
    `CHK("gdcfg_out", 32'h0, gate_driver_config_one)
    give_verdict();
  end
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
endmodule
